//--- ssp_pkg.sv
// package for the synchronous serial port: register map, field positions, reset values
// assumes a byte-wide register port and one 20 MHz clock
package ssp_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [2:0] SSP_ADDR_BUFFER = 3'h0;
  localparam logic [2:0] SSP_ADDR_STATUS = 3'h1;
  localparam logic [2:0] SSP_ADDR_CTRL_ONE = 3'h2;
  localparam logic [2:0] SSP_ADDR_CTRL_TWO = 3'h3;
  localparam logic [2:0] SSP_ADDR_RATE = 3'h4;
  localparam logic [2:0] SSP_ADDR_FLAGS = 3'h5;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SSP_ST_BF = 0;
  localparam int SSP_ST_UA = 1;
  localparam int SSP_ST_RW = 2;
  localparam int SSP_ST_START = 3;
  localparam int SSP_ST_STOP = 4;
  localparam int SSP_ST_DA = 5;
  localparam int SSP_C1_WRITE_COLLISION_FLAG = 7;
  localparam int SSP_C1_EN = 5;
  localparam int SSP_C2_BROADCAST_CALL_ENABLE = 7;
  localparam int SSP_C2_ACKDT = 5;
  localparam int SSP_C2_ACKEN = 4;
  localparam int SSP_C2_RCEN = 3;
  localparam int SSP_C2_PEN = 2;
  localparam int SSP_C2_RSEN = 1;
  localparam int SSP_C2_SEN = 0;
  localparam int SSP_FL_IRQ = 0;
  localparam int SSP_FL_SCL_DIR = 1;
  localparam int SSP_FL_SDA_DIR = 2;
  localparam int SSP_FL_TEN = 3;

  // ****************************************************************
  // reset values and mode codes
  // ****************************************************************
  localparam logic [7:0] SSP_RST_BYTE = 8'h00;
  localparam logic [7:0] SSP_RST_FLAGS = 8'h06;
  localparam logic [6:0] SSP_RST_RATE = 7'h09;
  localparam logic [3:0] SSP_MODE_MASTER = 4'h8;
  localparam logic [3:0] SSP_MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] SSP_MODE_SLAVE10 = 4'h7;
  localparam logic [7:0] SSP_BROADCAST = 8'h00;
  localparam logic [3:0] SSP_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] SSP_QUARTER_LAST = 2'h3;

  typedef enum logic [3:0] {
    SSP_IDLE, SSP_START_A, SSP_START_B, SSP_RSTART_A, SSP_RSTART_B,
    SSP_STOP_A, SSP_STOP_B, SSP_BIT_LOW, SSP_BIT_HIGH, SSP_ACK_LOW, SSP_ACK_HIGH
  } ssp_state_e;

endpackage

//--- ssp_port.sv
// synchronous serial port: register file, i2c master engine, i2c slave address match
// assumes pins come from outside the clock domain; scl/sda are open-drain (oe high drives 0)
`timescale 1ns/10ps

// What this block does
// - complete received byte moves from shift register to buffer and sets irq flag
// - buffer write loads buffer and shift register together, no transmit buffering
// - control one fully writable; status only upper two bits writable
// - stop-seen and start-seen clear on reset and while port disabled
// - broadcast call enable makes all-zero address with write bit match
// - after start, eight bits compared; match copies byte, sets full, irq on ninth fall
// - ten-bit mode sets address-update after first half; firmware reloads address
// - broadcast in ten-bit mode skips second half, address-update stays clear
// - master chosen by mode select, port active only with enable set
// - master drives scl and sda only while direction bits say input
// - master offers start, repeated start, transmit, receive, acknowledge, stop
// - no queueing; buffer write during a pending operation is dropped, sets collision
// - master sets irq flag after start, stop, repeated start, byte and acknowledge
// - rate reload taken from lower seven bits of address register
// - buffer write starts generator; counts to zero, reloads automatically without stopping
// - generator decrements twice per instruction cycle, phases two and four
// - on completion generator stops and scl holds its last level
// - one scl period is two generator rollovers
module ssp_port
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic port_irq_flag
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] xfer_buffer;
    logic [7:0] serial_shift_register;
    logic [7:0] port_control_one;
    logic [7:0] port_control_two;
    logic [7:0] addr_or_rate_reg;
    logic [7:0] port_status_reg;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic [1:0] quarter;
    logic [6:0] rate_count;
    logic rate_run;
    ssp_state_e state;
    logic [3:0] bit_count;
    logic receiving;
    logic drive_scl_low;
    logic drive_sda_low;
    logic sl_active;
    logic [3:0] sl_bits;
    logic sl_addr_phase;
    logic sl_second_half;
    logic sl_ack_pending;
  } ssp_state_s;

  ssp_state_s state_reg;
  ssp_state_s state_next;

  logic scl_s;
  logic sda_s;
  logic enabled;
  logic master;
  logic ten_bit;
  logic tick;
  logic rollover;
  logic start_seen;
  logic stop_seen;
  logic scl_fall;
  logic scl_rise;

  assign scl_s = state_reg.scl_sync[1];
  assign sda_s = state_reg.sda_sync[1];
  assign enabled = state_reg.port_control_one[SSP_C1_EN];
  assign master = enabled && state_reg.port_control_one[3:0] == SSP_MODE_MASTER;
  assign ten_bit = state_reg.port_control_one[3:0] == SSP_MODE_SLAVE10;
  // phases two and four of a four-clock instruction cycle
  assign tick = state_reg.quarter[0];
  assign rollover = tick && state_reg.rate_run && state_reg.rate_count == 7'h00;
  assign start_seen = state_reg.scl_prev && scl_s && state_reg.sda_prev && !sda_s;
  assign stop_seen = state_reg.scl_prev && scl_s && !state_reg.sda_prev && sda_s;
  assign scl_fall = state_reg.scl_prev && !scl_s;
  assign scl_rise = !state_reg.scl_prev && scl_s;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic busy;
    logic set_irq;
    logic matched;
    logic set_bf;
    logic set_ua;
    busy = 1'b0;
    set_irq = 1'b0;
    matched = 1'b0;
    set_bf = 1'b0;
    set_ua = 1'b0;
    state_next = state_reg;
    state_next.scl_sync = {state_reg.scl_sync[0], scl_in};
    state_next.sda_sync = {state_reg.sda_sync[0], sda_in};
    state_next.scl_prev = scl_s;
    state_next.sda_prev = sda_s;
    state_next.quarter = state_reg.quarter + 2'h1;
    state_next.rdata = SSP_RST_BYTE;
    busy = state_reg.state != SSP_IDLE;

    // baud generator, counts down then reloads from the low seven bits
    if (tick && state_reg.rate_run) begin
      if (state_reg.rate_count == 7'h00) begin
        state_next.rate_count = state_reg.addr_or_rate_reg[6:0];
      end else begin
        state_next.rate_count = state_reg.rate_count - 7'h01;
      end
    end

    // master sequencer: each phase is one rollover, a bit is low + high
    case (state_reg.state)
      SSP_IDLE: begin
        state_next.rate_run = 1'b0;
      end
      SSP_START_A: if (rollover) begin
        state_next.drive_sda_low = 1'b1;
        state_next.state = SSP_START_B;
      end
      SSP_START_B: if (rollover) begin
        state_next.drive_scl_low = 1'b1;
        state_next.state = SSP_IDLE;
        set_irq = 1'b1;
      end
      SSP_RSTART_A: if (rollover) begin
        state_next.drive_scl_low = 1'b0;
        state_next.state = SSP_RSTART_B;
      end
      SSP_RSTART_B: if (rollover && scl_s) begin
        state_next.drive_sda_low = 1'b1;
        state_next.state = SSP_START_B;
      end
      SSP_STOP_A: if (rollover) begin
        state_next.drive_scl_low = 1'b0;
        state_next.state = SSP_STOP_B;
      end
      SSP_STOP_B: if (rollover && scl_s) begin
        state_next.drive_sda_low = 1'b0;
        state_next.state = SSP_IDLE;
        set_irq = 1'b1;
      end
      SSP_BIT_LOW: if (rollover) begin
        state_next.drive_scl_low = 1'b0;
        state_next.state = SSP_BIT_HIGH;
      end
      SSP_BIT_HIGH: begin
        // stretched clock: keep reloading the count until the line is really high
        if (!scl_s) begin
          state_next.rate_count = state_reg.addr_or_rate_reg[6:0];
        end else if (rollover) begin
          state_next.drive_scl_low = 1'b1;
          state_next.serial_shift_register = {state_reg.serial_shift_register[6:0], sda_s};
          state_next.bit_count = state_reg.bit_count + 4'h1;
          if (state_reg.bit_count == SSP_BITS_PER_BYTE - 4'h1) begin
            state_next.drive_sda_low = 1'b0;
            if (state_reg.receiving) begin
              state_next.xfer_buffer = {state_reg.serial_shift_register[6:0], sda_s};
              state_next.port_status_reg[SSP_ST_BF] = 1'b1;
              set_bf = 1'b1;
              state_next.port_control_two[SSP_C2_RCEN] = 1'b0;
              state_next.state = SSP_IDLE;
              set_irq = 1'b1;
            end else begin
              state_next.state = SSP_ACK_LOW;
            end
          end else begin
            state_next.drive_sda_low = !state_reg.receiving
                                     && !state_reg.serial_shift_register[6];
            state_next.state = SSP_BIT_LOW;
          end
        end
      end
      SSP_ACK_LOW: if (rollover) begin
        state_next.drive_scl_low = 1'b0;
        state_next.state = SSP_ACK_HIGH;
      end
      SSP_ACK_HIGH: begin
        if (!scl_s) begin
          state_next.rate_count = state_reg.addr_or_rate_reg[6:0];
        end else if (rollover) begin
          // operation done: generator parks, scl held low
          state_next.drive_scl_low = 1'b1;
          state_next.drive_sda_low = 1'b0;
          state_next.port_control_two[SSP_C2_ACKEN] = 1'b0;
          state_next.port_status_reg[SSP_ST_BF] = 1'b0;
          state_next.state = SSP_IDLE;
          set_irq = 1'b1;
        end
      end
      default: state_next.state = SSP_IDLE;
    endcase

    // slave address matching, off the synchronised pins
    if (enabled && !master) begin
      if (start_seen) begin
        state_next.sl_active = 1'b1;
        state_next.sl_bits = 4'h0;
        state_next.sl_addr_phase = 1'b1;
        state_next.sl_second_half = 1'b0;
      end else if (state_reg.sl_active && scl_rise && state_reg.sl_bits < SSP_BITS_PER_BYTE) begin
        state_next.serial_shift_register = {state_reg.serial_shift_register[6:0], sda_s};
        state_next.sl_bits = state_reg.sl_bits + 4'h1;
      end else if (state_reg.sl_active && scl_fall) begin
        if (state_reg.sl_bits == SSP_BITS_PER_BYTE && !state_reg.sl_ack_pending) begin
          matched = state_reg.serial_shift_register == state_reg.addr_or_rate_reg
                 || (state_reg.port_control_two[SSP_C2_BROADCAST_CALL_ENABLE]
                     && state_reg.serial_shift_register == SSP_BROADCAST);
          if (matched || !state_reg.sl_addr_phase) begin
            state_next.xfer_buffer = state_reg.serial_shift_register;
            state_next.port_status_reg[SSP_ST_BF] = 1'b1;
            set_bf = 1'b1;
            state_next.drive_sda_low = 1'b1;
            state_next.sl_ack_pending = 1'b1;
            if (state_reg.sl_addr_phase && ten_bit && !state_reg.sl_second_half
                && state_reg.serial_shift_register != SSP_BROADCAST) begin
              state_next.port_status_reg[SSP_ST_UA] = 1'b1;
              set_ua = 1'b1;
              state_next.sl_second_half = 1'b1;
            end else begin
              state_next.sl_addr_phase = 1'b0;
              state_next.sl_second_half = 1'b0;
            end
          end else begin
            state_next.sl_active = 1'b0;
          end
        end else if (state_reg.sl_ack_pending) begin
          // falling edge of the ninth clock
          state_next.drive_sda_low = 1'b0;
          state_next.sl_ack_pending = 1'b0;
          state_next.sl_bits = 4'h0;
          set_irq = 1'b1;
        end
      end
    end

    // bus condition flags
    if (start_seen) begin
      state_next.port_status_reg[SSP_ST_START] = 1'b1;
      state_next.port_status_reg[SSP_ST_STOP] = 1'b0;
    end
    if (stop_seen) begin
      state_next.port_status_reg[SSP_ST_STOP] = 1'b1;
      state_next.port_status_reg[SSP_ST_START] = 1'b0;
      state_next.sl_active = 1'b0;
    end

    // register writes
    if (reg_write) begin
      case (reg_addr)
        SSP_ADDR_BUFFER: begin
          if (master && busy) begin
            state_next.port_control_one[SSP_C1_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            state_next.xfer_buffer = reg_wdata;
            state_next.serial_shift_register = reg_wdata;
            if (master) begin
              state_next.state = SSP_BIT_LOW;
              state_next.receiving = 1'b0;
              state_next.bit_count = 4'h0;
              state_next.drive_sda_low = !reg_wdata[7];
              state_next.rate_run = 1'b1;
              state_next.rate_count = state_reg.addr_or_rate_reg[6:0];
            end
          end
        end
        SSP_ADDR_STATUS: state_next.port_status_reg[7:6] = reg_wdata[7:6];
        SSP_ADDR_CTRL_ONE: state_next.port_control_one = reg_wdata;
        SSP_ADDR_CTRL_TWO: begin
          state_next.port_control_two = reg_wdata;
          if (master && !busy) begin
            state_next.rate_run = |reg_wdata[4:0];
            state_next.rate_count = state_reg.addr_or_rate_reg[6:0];
            if (reg_wdata[SSP_C2_SEN]) begin
              state_next.state = SSP_START_A;
            end else if (reg_wdata[SSP_C2_RSEN]) begin
              state_next.state = SSP_RSTART_A;
            end else if (reg_wdata[SSP_C2_PEN]) begin
              state_next.drive_sda_low = 1'b1;
              state_next.state = SSP_STOP_A;
            end else if (reg_wdata[SSP_C2_RCEN]) begin
              state_next.receiving = 1'b1;
              state_next.bit_count = 4'h0;
              state_next.drive_sda_low = 1'b0;
              state_next.state = SSP_BIT_LOW;
            end else if (reg_wdata[SSP_C2_ACKEN]) begin
              state_next.drive_sda_low = !reg_wdata[SSP_C2_ACKDT];
              state_next.state = SSP_ACK_LOW;
            end
          end else if (master && |reg_wdata[4:0]) begin
            state_next.port_control_one[SSP_C1_WRITE_COLLISION_FLAG] = 1'b1;
          end
        end
        SSP_ADDR_RATE: begin
          state_next.addr_or_rate_reg = reg_wdata;
          state_next.port_status_reg[SSP_ST_UA] = set_ua;
        end
        SSP_ADDR_FLAGS: state_next.flags = reg_wdata & ~8'h01;
        default: ;
      endcase
    end

    // irq flag: software clear loses to a same-cycle set
    if (reg_write && reg_addr == SSP_ADDR_FLAGS && !reg_wdata[SSP_FL_IRQ]) begin
      state_next.flags[SSP_FL_IRQ] = 1'b0;
    end else begin
      state_next.flags[SSP_FL_IRQ] = state_reg.flags[SSP_FL_IRQ];
    end
    if (set_irq) begin
      state_next.flags[SSP_FL_IRQ] = 1'b1;
    end

    // reads; reading the buffer empties it
    if (reg_read) begin
      case (reg_addr)
        SSP_ADDR_BUFFER: begin
          state_next.rdata = state_reg.xfer_buffer;
          state_next.port_status_reg[SSP_ST_BF] = set_bf;
        end
        SSP_ADDR_STATUS: state_next.rdata = state_reg.port_status_reg;
        SSP_ADDR_CTRL_ONE: state_next.rdata = state_reg.port_control_one;
        SSP_ADDR_CTRL_TWO: state_next.rdata = state_reg.port_control_two;
        SSP_ADDR_RATE: state_next.rdata = state_reg.addr_or_rate_reg;
        SSP_ADDR_FLAGS: state_next.rdata = state_reg.flags;
        default: state_next.rdata = SSP_RST_BYTE;
      endcase
    end

    // disabled port: drop bus conditions and release the lines
    if (!enabled) begin
      state_next.port_status_reg[SSP_ST_START] = 1'b0;
      state_next.port_status_reg[SSP_ST_STOP] = 1'b0;
      state_next.state = SSP_IDLE;
      state_next.rate_run = 1'b0;
      state_next.drive_scl_low = 1'b0;
      state_next.drive_sda_low = 1'b0;
      state_next.sl_active = 1'b0;
      state_next.sl_ack_pending = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.scl_sync <= 2'h3;
      state_reg.sda_sync <= 2'h3;
      state_reg.scl_prev <= 1'b1;
      state_reg.sda_prev <= 1'b1;
      state_reg.addr_or_rate_reg <= {1'b0, SSP_RST_RATE};
      state_reg.flags <= SSP_RST_FLAGS;
      state_reg.state <= SSP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // in master mode the lines stay released unless the direction bits hand them to the port
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = state_reg.drive_scl_low
               && (!master || state_reg.flags[SSP_FL_SCL_DIR]);
  assign sda_oe = state_reg.drive_sda_low
               && (!master || state_reg.flags[SSP_FL_SDA_DIR]);
  assign reg_rdata = state_reg.rdata;
  assign port_irq_flag = state_reg.flags[SSP_FL_IRQ];

endmodule

//--- ssp_port_properties.sv
// checker for the serial port: register access, irq flag, pin gating
// assumes binding to ssp_port; one clock, asynchronous active-low reset
`timescale 1ns/10ps
module ssp_port_properties
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic port_irq_flag
);
  // ****************************************************************
  // shadow of the enable, mode and scl direction settings
  // ****************************************************************
  logic en_q;
  logic master_q;
  logic scl_dir_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      master_q <= 1'b0;
      scl_dir_q <= 1'b1;
    end else if (reg_write && reg_addr == SSP_ADDR_CTRL_ONE) begin
      en_q <= reg_wdata[SSP_C1_EN];
      master_q <= (reg_wdata[3:0] == SSP_MODE_MASTER);
    end else if (reg_write && reg_addr == SSP_ADDR_FLAGS) begin
      scl_dir_q <= reg_wdata[SSP_FL_SCL_DIR];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****************************************************************
  // properties
  // ****************************************************************
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_pins_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output level not zero");
  a_status_upper_rw: assert property ((reg_write && reg_addr == SSP_ADDR_STATUS ##1
    reg_read && reg_addr == SSP_ADDR_STATUS) |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 2))
    else $error("status upper bits not written");
  a_ctrl_one_rw: assert property ((reg_write && reg_addr == SSP_ADDR_CTRL_ONE ##1
    reg_read && reg_addr == SSP_ADDR_CTRL_ONE) |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
    else $error("control one mode not written");
  a_rate_seven_bits: assert property ((reg_write && reg_addr == SSP_ADDR_RATE ##1
    reg_read && reg_addr == SSP_ADDR_RATE) |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
    else $error("rate reload bits not written");
  a_irq_sticky: assert property (port_irq_flag && !(reg_write &&
    reg_addr == SSP_ADDR_FLAGS) |=> port_irq_flag)
    else $error("irq flag dropped without software clear");
  a_off_quiet: assert property (!en_q [*2] |-> !scl_oe && !sda_oe)
    else $error("pins driven while port disabled");
  a_dir_gate: assert property ((en_q && master_q && !scl_dir_q) [*2] |-> !scl_oe)
    else $error("scl driven with direction bit clear");
  a_off_flags: assert property ((!en_q [*2] ##0 (reg_read &&
    reg_addr == SSP_ADDR_STATUS)) |=> reg_rdata[4:3] == 2'b00)
    else $error("start or stop seen while disabled");
  c_irq: cover property ($rose(port_irq_flag));
  c_scl_drive: cover property ($rose(scl_oe));
  c_tx_write: cover property (reg_write && reg_addr == SSP_ADDR_BUFFER && en_q && master_q);
endmodule
bind ssp_port ssp_port_properties ssp_port_properties_i (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .port_irq_flag(port_irq_flag));

//--- ssp_i2c_target.sv
// bus target model: takes one byte after a start, acks it, may stretch scl
// assumes pulled-up scl and sda levels, sampled on the bench clock
`timescale 1ns/10ps
module ssp_i2c_target (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic [3:0] stretch,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] got_byte
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [3:0] bit_cnt = 4'h9;
  logic [3:0] hold_cnt = 4'h0;
  logic [7:0] shift_reg = 8'h00;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    got_byte = 8'h00;
  end
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      bit_cnt <= 4'h0;
    end else if (scl && !scl_q && bit_cnt < 4'h8) begin
      shift_reg <= {shift_reg[6:0], sda};
      bit_cnt <= bit_cnt + 4'h1;
    end
    if (!scl && scl_q) begin
      hold_cnt <= stretch;
      // slow target: master must not count high phase early
      scl_pull <= (stretch != 4'h0);
      sda_pull <= (bit_cnt == 4'h8) && !sda_pull;
      if (bit_cnt == 4'h8 && !sda_pull) begin
        got_byte <= shift_reg;
      end
      if (sda_pull) begin
        bit_cnt <= 4'h9;
      end
    end else if (hold_cnt > 4'h1) begin
      hold_cnt <= hold_cnt - 4'h1;
    end else begin
      scl_pull <= 1'b0;
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench: register access, master start, transmit, stop, pin gating
// assumes ssp_port with its bound checker and the bus target model
`timescale 1ns/10ps
module tb_top;
  import ssp_pkg::*;
  logic clk;
  logic reset_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, port_irq_flag;
  logic t_scl_pull, t_sda_pull, rd_prev;
  logic [7:0] got_byte, tx_byte, ctl_val;
  logic [3:0] stretch;
  logic [7:0] exp_q[$];
  logic [7:0] mask_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  wire scl_bus = !(scl_oe | t_scl_pull);
  wire sda_bus = !(sda_oe | t_sda_pull);
  ssp_port ssp_port_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .scl_in(scl_bus), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .port_irq_flag(port_irq_flag));
  ssp_i2c_target ssp_i2c_target_i (.clk(clk), .scl(scl_bus), .sda(sda_bus),
    .stretch(stretch), .scl_pull(t_scl_pull), .sda_pull(t_sda_pull), .got_byte(got_byte));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // write then read with no gap between the strobes
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e,
      input logic [7:0] m);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  // the note is queued here; the monitor below compares when the answer appears
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (port_irq_flag !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check({7'h00, port_irq_flag}, 8'h01);
  endtask
  always @(posedge clk) rd_prev <= reg_read;
  always @(negedge clk) begin
    if (rd_prev) begin
      check(reg_rdata & mask_q.pop_front(), exp_q.pop_front());
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    rd_prev = 1'b0;
    stretch = 4'h0;
    void'($urandom(32'he7b7adbe));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(SSP_ADDR_STATUS, SSP_RST_BYTE, 8'hff);
    rd(SSP_ADDR_CTRL_ONE, SSP_RST_BYTE, 8'hff);
    rd(SSP_ADDR_RATE, {1'b0, SSP_RST_RATE}, 8'h7f);
    rd(SSP_ADDR_FLAGS, SSP_RST_FLAGS, 8'h07);
    rd(3'h7, 8'h00, 8'hff);
    $display("test reset values done");
    ctl_val = 8'($urandom()) & 8'h4f;
    wr_rd(SSP_ADDR_CTRL_ONE, ctl_val, ctl_val, 8'hef);
    wr_rd(SSP_ADDR_STATUS, 8'hff, 8'hc0, 8'hff);
    $display("test register access done");
    // lowest reload allowed, so the run stays short
    wr_rd(SSP_ADDR_RATE, 8'h02, 8'h02, 8'h7f);
    wr(SSP_ADDR_CTRL_ONE, {2'b00, 1'b1, 1'b0, SSP_MODE_MASTER});
    wr(SSP_ADDR_CTRL_TWO, 8'h01);
    wr(SSP_ADDR_BUFFER, 8'h5a);
    rd(SSP_ADDR_CTRL_ONE, 8'h80, 8'h80);
    wait_irq();
    rd(SSP_ADDR_STATUS, 8'h08, 8'h18);
    wr(SSP_ADDR_CTRL_ONE, 8'h28);
    wr(SSP_ADDR_FLAGS, 8'h06);
    $display("test start and collision done");
    tx_byte = 8'($urandom());
    stretch = 4'h3;
    wr(SSP_ADDR_BUFFER, tx_byte);
    wait_irq();
    check(got_byte, tx_byte);
    rd(SSP_ADDR_BUFFER, tx_byte, 8'hff);
    repeat (20) @(posedge clk);
    check({7'h00, scl_oe}, 8'h01);
    $display("test transmit done");
    wr(SSP_ADDR_FLAGS, 8'h06);
    wr(SSP_ADDR_CTRL_TWO, 8'h04);
    wait_irq();
    // stop flag lags the irq by the pin synchroniser
    repeat (4) @(posedge clk);
    rd(SSP_ADDR_STATUS, 8'h10, 8'h18);
    check({6'h00, scl_bus, sda_bus}, 8'h03);
    $display("test stop done");
    // direction bits clear: a start request must leave both pins alone
    wr(SSP_ADDR_FLAGS, 8'h00);
    wr(SSP_ADDR_CTRL_TWO, 8'h01);
    repeat (30) @(posedge clk);
    check({6'h00, scl_oe, sda_oe}, 8'h00);
    wr(SSP_ADDR_CTRL_ONE, 8'h08);
    rd(SSP_ADDR_STATUS, 8'h00, 8'h18);
    $display("test gating and disable done");
    repeat (3) @(posedge clk);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("BAD t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
    final_report();
  end
endmodule
